// [design/nds_pkg.sv]
// Purpose: Shared constants and types for the network diagnostic status block
// Assumes: 10 MHz clock, Wishbone slave with 32-bit data, byte addresses
// Notes:   Each offset, bit position, reset value and time is named once here
package nds_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] ADR_DIAG    = 8'h00;
  localparam logic [7:0] ADR_MAIN    = 8'h04;
  localparam logic [7:0] ADR_PROBE   = 8'h08;
  localparam logic [7:0] ADR_NEXTID  = 8'h0C;
  localparam logic [7:0] ADR_CTRL    = 8'h10;
  localparam logic [7:0] ADR_NODEID  = 8'h14;
  localparam logic [7:0] ADR_IRQSTAT = 8'h18;
  localparam logic [7:0] ADR_IRQMASK = 8'h1C;

  // ==========================================================================
  // Diagnostic status bit positions
  localparam int DG_SELF_REBUILD = 7;
  localparam int DG_DUPLICATE    = 6;
  localparam int DG_LINE_ACT     = 5;
  localparam int DG_TOKEN_SEEN   = 4;
  localparam int DG_EXCESS_NAK   = 3;
  localparam int DG_PROBE_MATCH  = 2;
  localparam int DG_SUCCESSOR    = 1;

  // Main status and interrupt layout
  localparam int MS_REBUILD      = 2;

  // Control register bits
  localparam int CT_NAK_SEL_LOW  = 0;
  localparam int CT_CLEAR_FLAGS  = 1;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] DIAG_RST    = 8'h00;
  localparam logic [7:0] ID_RST      = 8'h00;
  localparam logic [7:0] MASK_RST    = 8'h00;
  localparam logic [1:0] CTRL_RST    = 2'h0;

  // ==========================================================================
  // Refusal thresholds
  localparam logic [7:0] NAK_LIMIT_HIGH = 8'h80;
  localparam logic [7:0] NAK_LIMIT_LOW  = 8'h04;

  // ==========================================================================
  // Timing
  localparam int CLK_KHZ       = 10000;
  localparam int LINE_IDLE_US  = 41;
  localparam int IDLE_CYC      = (LINE_IDLE_US * CLK_KHZ + 999) / 1000;
  localparam logic [8:0] IDLE_LAST = 9'(IDLE_CYC - 1);

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic       valid;
    logic [7:0] firstDest;
    logic [7:0] secondDest;
    logic       zerosOk;
    logic       responded;
    logic       fromSelf;
  } nds_token_t;

  typedef struct packed {
    logic       lostTokenExpire;
    logic       nakSeen;
    logic       enquiryAccepted;
    logic       nextIdLoad;
    logic [7:0] nextIdValue;
    logic       onLine;
    logic       txEnabled;
  } nds_link_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } nds_bus_t;

endpackage

// [design/nds_sync.sv]
// Purpose: Three-stage synchroniser with agreement filter for a pin input
// Assumes: Input is asynchronous to clock
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ps
module nds_sync
(
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic pinIn,
  output logic      levelOut
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic level_nxt;

  // ==========================================================================
  // Filter
  always_comb
  begin
    level_nxt = level_r;
    if (s2_r == s3_r)
    begin
      level_nxt = s3_r;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end
    else
    begin
      s1_r    <= pinIn;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign levelOut = level_r;

endmodule

// [design/nds_status.sv]
// Purpose: Diagnostic status flags of a token-passing network node
// Assumes: Event inputs are same-clock pulses from the protocol engine
// Notes:   Wishbone classic slave, one wait state, unmapped reads zero
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module nds_status
  import nds_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire nds_pkg::nds_token_t token,
  input  wire nds_pkg::nds_link_t  link,
  input  wire logic               serial_receive_in,
  output logic                    irq
);

  import nds_pkg::*;

  // ==========================================================================
  // Declarations
  nds_bus_t    busState_r;
  nds_bus_t    busState_nxt;
  logic [31:0] rdData_r;
  logic [31:0] rdData_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic [7:0]  diag_r;
  logic [7:0]  diag_nxt;
  logic        rebuild_r;
  logic        rebuild_nxt;
  logic [7:0]  probeId_r;
  logic [7:0]  probeId_nxt;
  logic [7:0]  nextId_r;
  logic [7:0]  nextId_nxt;
  logic        nakSelLow_r;
  logic        nakSelLow_nxt;
  logic [7:0]  nodeId_r;
  logic [7:0]  nodeId_nxt;
  logic [7:0]  irqStat_r;
  logic [7:0]  irqStat_nxt;
  logic [7:0]  irqMask_r;
  logic [7:0]  irqMask_nxt;
  logic [7:0]  nakCnt_r;
  logic [7:0]  nakCnt_nxt;
  logic [8:0]  idleCnt_r;
  logic [8:0]  idleCnt_nxt;
  logic        rxLevel;
  logic        take;
  logic        wrLow;
  logic        rdDiag;
  logic        rdNext;
  logic        clearFlags;
  logic [7:0]  nakLimit;
  logic [7:0]  evtSet;

  // ==========================================================================
  // Functions
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction

  function automatic logic [7:0] w1c(input logic [7:0] cur,
                                     input logic [7:0] set,
                                     input logic [7:0] clr);
    w1c = (cur & ~clr) | set;
  endfunction

  // ==========================================================================
  // Receive pin synchroniser
  nds_sync u_rxSync
  (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .pinIn    (serial_receive_in),
    .levelOut (rxLevel)
  );

  // ==========================================================================
  // Bus decode
  assign take       = wb_cyc_i && wb_stb_i && (busState_r == BUS_IDLE);
  assign wrLow      = take && wb_we_i && wb_sel_i[0];
  assign rdDiag     = take && !wb_we_i && hit(wb_adr_i, ADR_DIAG);
  assign rdNext     = take && !wb_we_i && hit(wb_adr_i, ADR_NEXTID);
  assign clearFlags = wrLow && hit(wb_adr_i, ADR_CTRL)
                      && wb_dat_i[CT_CLEAR_FLAGS];
  assign nakLimit   = nakSelLow_r ? NAK_LIMIT_LOW : NAK_LIMIT_HIGH;

  always_comb
  begin
    busState_nxt = BUS_IDLE;
    rdData_nxt   = rdData_r;
    unique case (busState_r)
      BUS_IDLE:
      begin
        if (take)
        begin
          busState_nxt = BUS_ACK;
          rdData_nxt   = 32'h0000_0000;
          if (!wb_we_i)
          begin
            if (hit(wb_adr_i, ADR_DIAG))
              rdData_nxt[7:0] = diag_r;
            else if (hit(wb_adr_i, ADR_MAIN))
              rdData_nxt[MS_REBUILD] = rebuild_r;
            else if (hit(wb_adr_i, ADR_PROBE))
              rdData_nxt[7:0] = probeId_r;
            else if (hit(wb_adr_i, ADR_NEXTID))
              rdData_nxt[7:0] = nextId_r;
            else if (hit(wb_adr_i, ADR_CTRL))
              rdData_nxt[CT_NAK_SEL_LOW] = nakSelLow_r;
            else if (hit(wb_adr_i, ADR_NODEID))
              rdData_nxt[7:0] = nodeId_r;
            else if (hit(wb_adr_i, ADR_IRQSTAT))
              rdData_nxt[7:0] = irqStat_r;
            else if (hit(wb_adr_i, ADR_IRQMASK))
              rdData_nxt[7:0] = irqMask_r;
          end
        end
      end
      BUS_ACK:
      begin
        busState_nxt = BUS_IDLE;
      end
      default:
      begin
        busState_nxt = BUS_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Software registers
  always_comb
  begin
    probeId_nxt   = probeId_r;
    nodeId_nxt    = nodeId_r;
    nakSelLow_nxt = nakSelLow_r;
    irqMask_nxt   = irqMask_r;
    if (wrLow)
    begin
      if (hit(wb_adr_i, ADR_PROBE))
        probeId_nxt = wb_dat_i[7:0];
      if (hit(wb_adr_i, ADR_NODEID))
        nodeId_nxt = wb_dat_i[7:0];
      if (hit(wb_adr_i, ADR_CTRL))
        nakSelLow_nxt = wb_dat_i[CT_NAK_SEL_LOW];
      if (hit(wb_adr_i, ADR_IRQMASK))
        irqMask_nxt = wb_dat_i[7:0];
    end
  end

  // ==========================================================================
  // Line idle timer and refusal counter
  always_comb
  begin
    idleCnt_nxt = idleCnt_r + 9'h001;
    if (rxLevel || (idleCnt_r == IDLE_LAST))
      idleCnt_nxt = 9'h000;
    nakCnt_nxt = nakCnt_r;
    if (link.nakSeen && (nakCnt_r != 8'hFF))
      nakCnt_nxt = nakCnt_r + 8'h01;
    if (clearFlags || link.enquiryAccepted)
      nakCnt_nxt = 8'h00;
  end

  // ==========================================================================
  // Flags
  always_comb
  begin
    evtSet      = 8'h00;
    diag_nxt    = diag_r;
    rebuild_nxt = rebuild_r;
    nextId_nxt  = nextId_r;

    // Clears first, so a coincident set wins
    if (clearFlags)
    begin
      diag_nxt[DG_EXCESS_NAK]   = 1'b0;
      diag_nxt[DG_SELF_REBUILD] = 1'b0;
      rebuild_nxt               = 1'b0;
    end
    if (rdDiag)
    begin
      diag_nxt[DG_DUPLICATE]   = 1'b0;
      diag_nxt[DG_LINE_ACT]    = 1'b0;
      diag_nxt[DG_TOKEN_SEEN]  = 1'b0;
      diag_nxt[DG_PROBE_MATCH] = 1'b0;
    end
    if (rdNext)
      diag_nxt[DG_SUCCESSOR] = 1'b0;

    if (link.lostTokenExpire)
      diag_nxt[DG_SELF_REBUILD] = 1'b1;
    if (token.valid && token.responded && token.zerosOk
        && (token.firstDest == nodeId_r)
        && (token.secondDest == nodeId_r))
      diag_nxt[DG_DUPLICATE] = 1'b1;
    if (token.valid && !token.fromSelf && link.onLine
        && link.txEnabled && (token.firstDest == nodeId_r))
      diag_nxt[DG_DUPLICATE] = 1'b1;
    if (rxLevel)
      diag_nxt[DG_LINE_ACT] = 1'b1;
    if (token.valid && !token.fromSelf)
      diag_nxt[DG_TOKEN_SEEN] = 1'b1;
    if (link.nakSeen && ((nakCnt_r + 8'h01) >= nakLimit))
      diag_nxt[DG_EXCESS_NAK] = 1'b1;
    if (token.valid && token.responded
        && (token.firstDest == probeId_r))
      diag_nxt[DG_PROBE_MATCH] = 1'b1;
    if (link.nextIdLoad)
    begin
      nextId_nxt             = link.nextIdValue;
      diag_nxt[DG_SUCCESSOR] = 1'b1;
    end
    if (!rxLevel && (idleCnt_r == IDLE_LAST))
      rebuild_nxt = 1'b1;
    diag_nxt[0] = 1'b0;

    // Interrupt sources follow the flag levels
    evtSet[DG_EXCESS_NAK] = diag_nxt[DG_EXCESS_NAK];
    evtSet[DG_SUCCESSOR]  = diag_nxt[DG_SUCCESSOR];
    evtSet[MS_REBUILD]    = rebuild_nxt;
  end

  // ==========================================================================
  // Interrupt
  always_comb
  begin
    irqStat_nxt = w1c(irqStat_r, evtSet,
                      (wrLow && hit(wb_adr_i, ADR_IRQSTAT))
                      ? wb_dat_i[7:0] : 8'h00);
    irq_nxt = |(irqStat_nxt & irqMask_nxt);
  end

  // ==========================================================================
  // State registers
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busState_r  <= BUS_IDLE;
      rdData_r    <= 32'h0000_0000;
      irq_r       <= 1'b0;
      diag_r      <= DIAG_RST;
      rebuild_r   <= 1'b0;
      probeId_r   <= ID_RST;
      nextId_r    <= ID_RST;
      nakSelLow_r <= 1'b0;
      nodeId_r    <= ID_RST;
      irqStat_r   <= MASK_RST;
      irqMask_r   <= MASK_RST;
      nakCnt_r    <= 8'h00;
      idleCnt_r   <= 9'h000;
    end
    else
    begin
      busState_r  <= busState_nxt;
      rdData_r    <= rdData_nxt;
      irq_r       <= irq_nxt;
      diag_r      <= diag_nxt;
      rebuild_r   <= rebuild_nxt;
      probeId_r   <= probeId_nxt;
      nextId_r    <= nextId_nxt;
      nakSelLow_r <= nakSelLow_nxt;
      nodeId_r    <= nodeId_nxt;
      irqStat_r   <= irqStat_nxt;
      irqMask_r   <= irqMask_nxt;
      nakCnt_r    <= nakCnt_nxt;
      idleCnt_r   <= idleCnt_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign wb_dat_o = rdData_r;
  assign wb_ack_o = (busState_r == BUS_ACK);
  assign irq      = irq_r;

endmodule

// [testbench/nds_status_chk.sv]
// Purpose: Concurrent checks on the diagnostic status ports
// Assumes: One clock domain, reset active high
// Notes:   Mask and probe id are mirrored from bus writes
`timescale 1ns/1ps
module nds_status_chk
  import nds_pkg::*;
(
  input wire logic                clock,
  input wire logic                sys_rst,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [7:0]          wb_adr_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  input wire nds_pkg::nds_token_t token,
  input wire nds_pkg::nds_link_t  link,
  input wire logic                serial_receive_in,
  input wire logic                irq
);
  logic [7:0] mask_r, mask_nxt, probe_r, probe_nxt;
  logic       wrAck;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // Mirrors of written registers
  assign wrAck = wb_ack_o && wb_we_i && wb_sel_i[0];
  always_comb
  begin
    mask_nxt = mask_r;
    probe_nxt = probe_r;
    if (wrAck && wb_adr_i == ADR_IRQMASK)
      mask_nxt = wb_dat_i[7:0];
    if (wrAck && wb_adr_i == ADR_PROBE)
      probe_nxt = wb_dat_i[7:0];
  end
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mask_r <= MASK_RST;
      probe_r <= ID_RST;
    end
    else
    begin
      mask_r <= mask_nxt;
      probe_r <= probe_nxt;
    end
  end

  // ==========================================================================
  // Answered reads
  sequence diagRd;
    wb_ack_o && !wb_we_i && wb_adr_i == ADR_DIAG;
  endsequence
  sequence nextRd;
    wb_ack_o && !wb_we_i && wb_adr_i == ADR_NEXTID;
  endsequence

  // ==========================================================================
  // Flag checks
  a_diag_spare:
    assert property (diagRd |-> wb_dat_o[0] == 1'b0)
    else $error("diag bit 0 not zero");
  a_self_rebuild:
    assert property (link.lostTokenExpire ##[2:3] diagRd |-> wb_dat_o[7])
    else $error("self rebuild flag missing");
  a_token_seen:
    assert property (token.valid && !token.fromSelf ##[2:3] diagRd
      |-> wb_dat_o[4])
    else $error("token seen flag missing");
  a_probe_hit:
    assert property (token.valid && token.responded
      && token.firstDest == probe_r ##[2:3] diagRd |-> wb_dat_o[2])
    else $error("probe match flag missing");
  a_dup_clear:
    assert property (!token.valid ##1 diagRd ##0 !token.valid
      ##1 !token.valid ##2 diagRd |-> !wb_dat_o[6])
    else $error("duplicate flag kept after read");
  a_excess_keep:
    assert property (diagRd ##0 wb_dat_o[3] ##[2:4] diagRd |-> wb_dat_o[3])
    else $error("excess flag lost on read");
  a_succ_keep:
    assert property (diagRd ##0 wb_dat_o[1] ##[2:4] diagRd |-> wb_dat_o[1])
    else $error("successor flag lost on read");
  a_succ_clear:
    assert property (!link.nextIdLoad ##1 nextRd ##0 !link.nextIdLoad
      ##1 !link.nextIdLoad ##2 diagRd |-> !wb_dat_o[1])
    else $error("successor flag kept after next id read");
  a_irq_succ:
    assert property (link.nextIdLoad && mask_r[1] |-> ##[1:3] irq)
    else $error("interrupt missing for successor");
endmodule

bind nds_status nds_status_chk u_chk
(
  .clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .token(token), .link(link),
  .serial_receive_in(serial_receive_in), .irq(irq)
);

// [testbench/nds_node_model.sv]
// Purpose: Far-side node and protocol engine model
// Assumes: Event pulses last one clock
// Notes:   Serial line idles low; link levels kept between pulses
`timescale 1ns/1ps
module nds_node_model
  import nds_pkg::*;
(
  input  wire logic          clock,
  output nds_pkg::nds_token_t tok,
  output nds_pkg::nds_link_t  lnk,
  output logic               rxLine
);
  initial
  begin
    tok = '0;
    lnk = '0;
    rxLine = 1'b0;
  end

  // ==========================================================================
  // Pulses and line level
  task automatic sendTok(input nds_token_t t);
    @(posedge clock);
    tok <= t;
    @(posedge clock);
    tok.valid <= 1'b0;
  endtask
  task automatic pulse(input nds_link_t l);
    @(posedge clock);
    lnk <= l;
    @(posedge clock);
    lnk <= l & 14'h0003;
  endtask
  task automatic line(input logic v);
    @(posedge clock);
    rxLine <= v;
  endtask
endmodule

// [testbench/network_diagnostic_status_test.sv]
// Purpose: Self-checking bench for the diagnostic status flags
// Assumes: One wait state Wishbone answer
// Notes:   Flag byte model updated per event
`timescale 1ns/1ps
module network_diagnostic_status_test;
  import nds_pkg::*;
  logic        clock, sys_rst, cyc, stb, we, irq, ack, rx, onl, selLow;
  logic [3:0]  sel;
  logic [7:0]  adr, mdl, nid, prb, nxt;
  logic [31:0] dati, dato, q, rnd;
  nds_token_t  tok;
  nds_link_t   lnk;
  int          n_fail, checks;

  nds_status DUT (.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dati), .wb_dat_o(dato), .wb_ack_o(ack), .token(tok),
    .link(lnk), .serial_receive_in(rx), .irq(irq));
  nds_node_model peer (.clock(clock), .tok(tok), .lnk(lnk), .rxLine(rx));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    n_fail++;
    tally_and_finish;
  end

  // ==========================================================================
  // Tasks
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tally_and_finish;
    if (n_fail == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpIrq(input logic e);
    repeat (2) @(posedge clock);
    cmp({31'h0000_0000, irq}, {31'h0000_0000, e});
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    rnd = lfsr(rnd);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= {rnd[2:0], selLow};
    dati <= {rnd[31:8], d};
    do
    begin
      @(posedge clock);
    end
    while (ack !== 1'b1);
    q = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    cmp(q, {24'h00_0000, e});
  endtask
  task automatic rdDiag;
    rdc(ADR_DIAG, mdl);
    mdl &= 8'h8B;
  endtask
  task automatic clrf(input logic lo);
    wb(1'b1, ADR_CTRL, {6'h00, 1'b1, lo});
    mdl &= 8'h77;
  endtask
  task automatic tk(input logic [7:0] f, s, input logic z, r, m);
    peer.sendTok('{1'b1, f, s, z, r, m});
    if (!m)
      mdl[4] = 1'b1;
    if (r && f == prb)
      mdl[2] = 1'b1;
    if (!m && f == nid && ((s == nid && z && r) || onl))
      mdl[6] = 1'b1;
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    n_fail = 0;
    checks = 0;
    {cyc, stb, we, onl} = 4'h0;
    selLow = 1'b1;
    sel = 4'hF;
    adr = 8'h00;
    dati = 32'h0000_0000;
    mdl = 8'h00;
    prb = 8'h00;
    sys_rst = 1'b1;
    rnd = lfsr(32'h5b69_6d79);
    nid = rnd[7:0] | 8'h01;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    rdDiag;
    cmpIrq(1'b0);
    wb(1'b1, ADR_NODEID, nid);
    rdc(ADR_NODEID, nid);
    peer.pulse(14'h2000);
    mdl[7] = 1'b1;
    rdDiag;
    tk(nid, nid, 1'b0, 1'b1, 1'b0);
    rdDiag;
    tk(nid, nid, 1'b1, 1'b1, 1'b0);
    rdDiag;
    rdDiag;
    tk(~nid, nid, 1'b1, 1'b0, 1'b1);
    rdDiag;
    peer.pulse(14'h0003);
    onl = 1'b1;
    tk(nid, ~nid, 1'b0, 1'b0, 1'b0);
    rdDiag;
    peer.pulse(14'h0000);
    onl = 1'b0;
    prb = rnd[15:8];
    wb(1'b1, ADR_PROBE, prb);
    selLow = 1'b0;
    wb(1'b1, ADR_PROBE, ~prb);
    selLow = 1'b1;
    rdc(ADR_PROBE, prb);
    tk(prb, ~prb, 1'b0, 1'b0, 1'b0);
    rdDiag;
    tk(prb, ~prb, 1'b0, 1'b1, 1'b0);
    rdDiag;
    peer.line(1'b1);
    repeat (6) @(posedge clock);
    peer.line(1'b0);
    repeat (6) @(posedge clock);
    mdl[5] = 1'b1;
    rdDiag;
    clrf(1'b0);
    repeat (300) @(posedge clock);
    rdc(ADR_MAIN, 8'h00);
    repeat (120) @(posedge clock);
    rdc(ADR_MAIN, 8'h04);
    clrf(1'b1);
    rdc(ADR_CTRL, 8'h01);
    repeat (3) peer.pulse(14'h1000);
    peer.pulse(14'h0800);
    repeat (3) peer.pulse(14'h1000);
    rdDiag;
    peer.pulse(14'h1000);
    mdl[3] = 1'b1;
    rdDiag;
    rdDiag;
    wb(1'b1, ADR_IRQMASK, 8'h08);
    cmpIrq(1'b1);
    clrf(1'b0);
    wb(1'b1, ADR_IRQSTAT, 8'h0E);
    cmpIrq(1'b0);
    rdDiag;
    repeat (127) peer.pulse(14'h1000);
    rdDiag;
    peer.pulse(14'h1000);
    mdl[3] = 1'b1;
    rdDiag;
    nxt = rnd[23:16];
    wb(1'b1, ADR_IRQMASK, 8'h02);
    rdc(ADR_IRQMASK, 8'h02);
    cmpIrq(1'b0);
    peer.pulse({4'h1, nxt, 2'h0});
    mdl[1] = 1'b1;
    cmpIrq(1'b1);
    rdDiag;
    rdDiag;
    rdc(ADR_NEXTID, nxt);
    mdl[1] = 1'b0;
    rdDiag;
    // Reset in mid-run
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    mdl = 8'h00;
    rdDiag;
    rdc(ADR_NODEID, ID_RST);
    cmpIrq(1'b0);
    tally_and_finish;
  end
endmodule
